// ### hdl/drive_port_end.sv
// connection layer core and its drive device end
//
// Summary of operation
// RL1: no characters move without a connection
// RL2: connections may close and reopen later
// RL3: each connection belongs to one session
// RL4: serial link connection implied by attachment
// RL5: connect and disconnect only on network ports
// RL6: drive device always listens, automation optionally
// RL7: listen on port 4169 or secure port
// RL8: secure port traffic must be TLS protected
// RL9: both ends report connected on establishment
// RL10: duplicate gets no connected, one closed
// RL11: closing duplicate raises no disconnect event
// RL12: mixed initiators: drive closes its own
// RL13: same initiator: earlier one closed
// RL14: connect refused unless session idle
// RL15: automation reset pulse gives reset indication
// RL16: each received needs a new receive
// RL17: requests and confirmations are one-cycle pulses
// RL18: one state per session, event driven
`include "pcm_consts.svh"

module port_conn_core
    import pcm_pkg::*;
#(
    parameter bit IS_DRIVE = 1'b1
) (
    input  wire logic  core_clk,
    input  wire logic  reset,
    input  wire logic  serial_mode,
    input  wire logic  phys_attached,
    input  wire logic  listen_en,
    input  wire logic  req_valid,
    input  req_kind_t  req_kind,
    input  sess_t      req_sess,
    input  char_t      req_data,
    input  wire logic  req_tls,
    output logic       req_ready,
    output logic       cnf_valid,
    output req_kind_t  cnf_kind,
    output sess_t      cnf_sess,
    output status_t    cnf_status,
    output logic       ind_valid,
    output ind_kind_t  ind_kind,
    output sess_t      ind_sess,
    output char_t      ind_data,
    output logic       reset_received,
    input  link_msg_t  in_msg,
    input  wire logic  rst_in,
    output link_msg_t  out_msg,
    output logic       rst_out
);
    sess_state_t state    [`PCM_NSESS];
    logic        by_drive [`PCM_NSESS];
    logic        tls      [`PCM_NSESS];
    logic        armed    [`PCM_NSESS];
    link_msg_t   pend;

    // request decode
    wire         take      = req_valid & req_ready;
    sess_state_t rs;
    assign rs = state[req_sess];
    wire         ser_ok    = serial_mode & phys_attached & (req_sess == `PCM_SERIAL_SESS);
    wire         link_ok   = serial_mode ? ser_ok : (rs == ST_CONNECTED); // RL1 RL4
    wire         is_conn   = req_kind == REQ_CONNECT;
    wire         is_disc   = req_kind == REQ_DISCONNECT;
    wire         is_xfer   = (req_kind == REQ_SEND) | (req_kind == REQ_RECEIVE);
    wire         is_rst    = req_kind == REQ_RESET;
    status_t     req_status;
    assign req_status =
        ((is_conn | is_disc) & serial_mode) ? RSP_NOT_SUPPORTED :        // RL5
        (is_rst & IS_DRIVE)                 ? RSP_NOT_SUPPORTED :
        (is_conn & rs != ST_IDLE)           ? RSP_INVALID_STATE :        // RL14
        (is_conn & ~phys_attached)          ? RSP_NO_PHYS :
        (is_disc & rs != ST_CONNECTED)      ? RSP_INVALID_STATE :
        (is_xfer & ~link_ok)                ? RSP_INVALID_STATE :        // RL1
                                              RSP_GOOD;
    wire         req_good  = take & (req_status == RSP_GOOD);

    // message caused by a request
    link_msg_t   req_msg;
    assign req_msg.valid = req_good & (is_conn | is_disc | req_kind == REQ_SEND);
    assign req_msg.kind  = is_conn ? MSG_OPEN : is_disc ? MSG_CLOSE : MSG_CHAR;
    assign req_msg.sess  = req_sess;
    assign req_msg.data  = req_data;
    assign req_msg.port  = req_tls ? `PCM_TLS_PORT : `PCM_TCP_PORT;       // RL7
    assign req_msg.flag  = is_conn ? req_tls : (~serial_mode & tls[req_sess]); // RL8

    // incoming message decode
    wire         iv        = in_msg.valid;
    sess_t       s;
    assign s = in_msg.sess;
    sess_state_t is_;
    assign is_ = state[s];
    wire         k_open    = iv & (in_msg.kind == MSG_OPEN);
    wire         k_ack     = iv & (in_msg.kind == MSG_OPEN_ACK);
    wire         k_nak     = iv & (in_msg.kind == MSG_OPEN_NAK);
    wire         k_char    = iv & (in_msg.kind == MSG_CHAR);
    wire         k_close   = iv & (in_msg.kind == MSG_CLOSE);
    wire         k_cack    = iv & (in_msg.kind == MSG_CLOSE_ACK);
    wire         tls_port  = in_msg.port == `PCM_TLS_PORT;
    wire         port_ok   = tls_port | (in_msg.port == `PCM_TCP_PORT);    // RL7
    wire         listening = IS_DRIVE | listen_en;                         // RL6
    // a plain segment on the secure port is turned away
    wire         accept    = k_open & ~serial_mode & phys_attached & listening & port_ok
                             & (is_ != ST_CLOSING) & (in_msg.flag == tls_port); // RL8
    wire         connected = is_ == ST_CONNECTED;
    wire         first     = by_drive[s];
    wire         peer_drv  = ~IS_DRIVE;
    wire         dup_open  = accept & connected;                            // RL10
    wire         dup_ack   = k_ack & connected;                             // RL10
    wire         second    = k_open ? peer_drv : IS_DRIVE;
    wire         i_close   = drive_closes(first, second) == IS_DRIVE;      // RL12 RL13
    wire         new_lives = (first == second) | ~second;                  // RL13
    wire         rx_path   = serial_mode ? (s == `PCM_SERIAL_SESS) & phys_attached
                                         : connected & (in_msg.flag == tls[s]);
    wire         rx_ok     = k_char & armed[s] & rx_path;                  // RL1 RL16

    // reply to the peer takes the link before queued requests
    link_msg_t   rep_msg;
    assign rep_msg.valid = k_open | (k_close & connected) | (dup_ack & i_close);
    assign rep_msg.kind  = k_open ? (accept ? MSG_OPEN_ACK : MSG_OPEN_NAK) :
                           k_close ? MSG_CLOSE_ACK : MSG_DUP_CLOSE;        // RL10
    assign rep_msg.sess  = s;
    assign rep_msg.data  = '0;
    assign rep_msg.port  = in_msg.port;
    assign rep_msg.flag  = dup_open & i_close;

    // indications; duplicates stay silent
    wire       fire_conn = (accept & ~connected) | (k_ack & is_ == ST_CONNECTING); // RL9 RL10
    wire       fire_fail = k_nak & (is_ == ST_CONNECTING);
    wire       fire_dr   = k_close & connected;
    wire       fire_dc   = (k_close | k_cack) & (is_ == ST_CLOSING);       // RL11
    ind_kind_t next_ind;
    assign next_ind = fire_conn ? IND_CONNECTED :
                      fire_fail ? IND_CONNECT_FAILED :
                      fire_dr   ? IND_DISCONNECT_RECEIVED :
                      fire_dc   ? IND_DISCONNECTED : IND_RECEIVED;

    // session update caused by the peer
    wire         in_upd = accept | (k_ack & (is_ == ST_CONNECTING | connected))
                          | fire_fail | fire_dr | fire_dc;
    sess_state_t next_in_state;
    assign next_in_state = (accept | k_ack) ? ST_CONNECTED : ST_IDLE;      // RL2
    wire         next_in_drv = (dup_open | dup_ack) ? survivor_drv(first, second)
                                                    : second;              // RL12 RL13
    // a fresh connection always takes its own security; an accepted duplicate only if it survives, an acked duplicate never
    wire         next_in_tls = (accept & (~connected | new_lives)) ? in_msg.flag : tls[s]; // RL8

    // confirmations, one cycle after the request is taken
    always_ff @(posedge core_clk) begin
        cnf_valid  <= ~reset & take;                                       // RL17
        cnf_kind   <= req_kind;
        cnf_sess   <= req_sess;
        cnf_status <= req_status;
    end

    // indications, one cycle after the peer's message; the reset line out one cycle after the request
    always_ff @(posedge core_clk) begin
        ind_valid      <= ~reset & (fire_conn | fire_fail | fire_dr | fire_dc | rx_ok);
        ind_kind       <= next_ind;
        ind_sess       <= s;
        ind_data       <= in_msg.data;
        reset_received <= ~reset & IS_DRIVE & rst_in;                      // RL15
        rst_out        <= ~reset & ~IS_DRIVE & req_good & is_rst;
    end

    // outgoing link and one-deep hold for a request that lost the link
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_msg   <= '0;
            pend      <= '0;
            req_ready <= 1'b0;
        end else if (rep_msg.valid) begin
            out_msg   <= rep_msg;
            pend      <= req_msg.valid ? req_msg : pend;
            req_ready <= ~(req_msg.valid | pend.valid);
        end else begin
            out_msg   <= pend.valid ? pend : req_msg;
            pend      <= '0;
            req_ready <= 1'b1;
        end
    end

    // per-session state; peer events land after request effects, except armed, where a receive request lands last
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < `PCM_NSESS; i++) begin
                state[i]    <= ST_IDLE;
                by_drive[i] <= 1'b0;
                tls[i]      <= 1'b0;
                armed[i]    <= 1'b0;
            end
        end else begin
            if (req_good & is_conn) begin
                state[req_sess] <= ST_CONNECTING;                          // RL18
                tls[req_sess]   <= req_tls;
            end
            if (req_good & is_disc)
                state[req_sess] <= ST_CLOSING;                             // RL18
            if (in_upd) begin
                state[s]    <= next_in_state;                              // RL3 RL18
                by_drive[s] <= next_in_drv;
                tls[s]      <= next_in_tls;
            end
            if (rx_ok | fire_dr | fire_dc)
                armed[s] <= 1'b0;                                          // RL16
            if (req_good & req_kind == REQ_RECEIVE)
                armed[req_sess] <= 1'b1;
        end
    end
endmodule

// drive device end: always listens, never asks for a reset
module drive_port_end
    import pcm_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       serial_mode,
    input  wire logic       phys_attached,
    input  wire logic       req_valid,
    input  req_kind_t       req_kind,
    input  sess_t           req_sess,
    input  char_t           req_data,
    input  wire logic       req_tls,
    output logic            req_ready,
    output logic            cnf_valid,
    output req_kind_t       cnf_kind,
    output sess_t           cnf_sess,
    output status_t         cnf_status,
    output logic            ind_valid,
    output ind_kind_t       ind_kind,
    output sess_t           ind_sess,
    output char_t           ind_data,
    output logic            reset_received,
    port_link_if.drive_end  link
);
    // reset line is an input here; the core's reset output stays unused
    port_conn_core #(.IS_DRIVE(1'b1)) core (
        .core_clk       (core_clk),
        .reset          (reset),
        .serial_mode    (serial_mode),
        .phys_attached  (phys_attached),
        .listen_en      (1'b1),
        .req_valid      (req_valid),
        .req_kind       (req_kind),
        .req_sess       (req_sess),
        .req_data       (req_data),
        .req_tls        (req_tls),
        .req_ready      (req_ready),
        .cnf_valid      (cnf_valid),
        .cnf_kind       (cnf_kind),
        .cnf_sess       (cnf_sess),
        .cnf_status     (cnf_status),
        .ind_valid      (ind_valid),
        .ind_kind       (ind_kind),
        .ind_sess       (ind_sess),
        .ind_data       (ind_data),
        .reset_received (reset_received),
        .in_msg         (link.a2d),
        .rst_in         (link.reset_a),
        .out_msg        (link.d2a),
        .rst_out        ()
    );
endmodule

// ### common/pcm_consts.svh
// timing-free constants of the port connection manager
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH
`define PCM_NSESS       4
`define PCM_SESS_W      2
`define PCM_CHAR_W      8
`define PCM_PORT_W      16
`define PCM_TCP_PORT    16'h1049
`define PCM_TLS_PORT    16'hfffe
`define PCM_SERIAL_SESS 2'h0
`endif

// ### common/pcm_pkg.sv
// types shared by both ends of the port connection manager
`include "pcm_consts.svh"
package pcm_pkg;
    typedef logic [`PCM_SESS_W-1:0] sess_t;
    typedef logic [`PCM_CHAR_W-1:0] char_t;
    typedef logic [`PCM_PORT_W-1:0] port_t;

    // gray codes along idle, connecting, connected, closing
    typedef enum logic [1:0] {
        ST_IDLE       = 2'h0,
        ST_CONNECTING = 2'h1,
        ST_CONNECTED  = 2'h3,
        ST_CLOSING    = 2'h2
    } sess_state_t;

    typedef enum logic [2:0] {
        REQ_CONNECT, REQ_SEND, REQ_RECEIVE, REQ_DISCONNECT, REQ_RESET
    } req_kind_t;

    typedef enum logic [1:0] {
        RSP_GOOD, RSP_INVALID_STATE, RSP_NOT_SUPPORTED, RSP_NO_PHYS
    } status_t;

    typedef enum logic [2:0] {
        IND_CONNECTED, IND_CONNECT_FAILED, IND_RECEIVED,
        IND_DISCONNECTED, IND_DISCONNECT_RECEIVED
    } ind_kind_t;

    typedef enum logic [2:0] {
        MSG_OPEN, MSG_OPEN_ACK, MSG_OPEN_NAK, MSG_CHAR,
        MSG_CLOSE, MSG_CLOSE_ACK, MSG_DUP_CLOSE
    } msg_kind_t;

    typedef struct packed {
        logic      valid;
        msg_kind_t kind;
        sess_t     sess;
        char_t     data;
        port_t     port;
        logic      flag;
    } link_msg_t;

    // the drive device closes unless both duplicates came from it
    function automatic logic drive_closes(input logic first_drv, input logic second_drv);
        return ~(first_drv & second_drv);
    endfunction

    // initiator of the connection that survives a duplicate
    function automatic logic survivor_drv(input logic first_drv, input logic second_drv);
        return first_drv & second_drv;
    endfunction
endpackage

// ### common/port_link_if.sv
// link between the drive device end and the automation end
interface port_link_if (input logic core_clk);
    import pcm_pkg::*;
    link_msg_t a2d;
    link_msg_t d2a;
    logic      reset_a;

    modport drive_end (input a2d, input reset_a, output d2a);
    modport auto_end  (output a2d, output reset_a, input d2a);
endinterface

// ### hdl/auto_port_end.sv
// automation device end of the connection layer
`include "pcm_consts.svh"

module auto_port_end
    import pcm_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      reset,
    input  wire logic      serial_mode,
    input  wire logic      phys_attached,
    input  wire logic      listen_en,
    input  wire logic      req_valid,
    input  req_kind_t      req_kind,
    input  sess_t          req_sess,
    input  char_t          req_data,
    input  wire logic      req_tls,
    output logic           req_ready,
    output logic           cnf_valid,
    output req_kind_t      cnf_kind,
    output sess_t          cnf_sess,
    output status_t        cnf_status,
    output logic           ind_valid,
    output ind_kind_t      ind_kind,
    output sess_t          ind_sess,
    output char_t          ind_data,
    port_link_if.auto_end  link
);
    // listening is optional here; reset requests drive the reset line
    port_conn_core #(.IS_DRIVE(1'b0)) core (
        .core_clk       (core_clk),
        .reset          (reset),
        .serial_mode    (serial_mode),
        .phys_attached  (phys_attached),
        .listen_en      (listen_en),
        .req_valid      (req_valid),
        .req_kind       (req_kind),
        .req_sess       (req_sess),
        .req_data       (req_data),
        .req_tls        (req_tls),
        .req_ready      (req_ready),
        .cnf_valid      (cnf_valid),
        .cnf_kind       (cnf_kind),
        .cnf_sess       (cnf_sess),
        .cnf_status     (cnf_status),
        .ind_valid      (ind_valid),
        .ind_kind       (ind_kind),
        .ind_sess       (ind_sess),
        .ind_data       (ind_data),
        .reset_received (),
        .in_msg         (link.d2a),
        .rst_in         (1'b0),
        .out_msg        (link.a2d),
        .rst_out        (link.reset_a)
    );
endmodule

// ### test/port_connection_manager_sva.sv
// link-level checker placed beside the interface joining both ends
`include "pcm_consts.svh"

module port_connection_manager_sva
    import pcm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input link_msg_t a2d,
    input link_msg_t d2a,
    input wire logic reset_a
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // message decode per direction
    wire a_open  = a2d.valid && a2d.kind == MSG_OPEN;
    wire d_open  = d2a.valid && d2a.kind == MSG_OPEN;
    wire a_close = a2d.valid && a2d.kind == MSG_CLOSE;
    wire d_close = d2a.valid && d2a.kind == MSG_CLOSE;
    wire a_ack   = a2d.valid && a2d.kind == MSG_OPEN_ACK;
    wire d_ack   = d2a.valid && d2a.kind == MSG_OPEN_ACK;
    wire a_nak   = a2d.valid && a2d.kind == MSG_OPEN_NAK;
    wire d_nak   = d2a.valid && d2a.kind == MSG_OPEN_NAK;
    wire a_cack  = a2d.valid && a2d.kind == MSG_CLOSE_ACK;
    wire d_cack  = d2a.valid && d2a.kind == MSG_CLOSE_ACK;
    wire a_dup   = a2d.valid && a2d.kind == MSG_DUP_CLOSE;
    wire d_dup   = d2a.valid && d2a.kind == MSG_DUP_CLOSE;

    // nothing leaks onto the link from state held over reset
    chk_reset_quiet: assert property (
        $fell(reset) |-> !a2d.valid && !d2a.valid && !reset_a)
        else $error("link active right after reset");
    chk_open_port_a: assert property (
        a_open |-> a2d.port == (a2d.flag ? `PCM_TLS_PORT : `PCM_TCP_PORT))
        else $error("auto open on wrong port");
    chk_open_port_d: assert property (
        d_open |-> d2a.port == (d2a.flag ? `PCM_TLS_PORT : `PCM_TCP_PORT))
        else $error("drive open on wrong port");
    // replies win over queued requests, so one cycle is exact
    chk_open_reply_d: assert property (
        a_open |=> (d_ack || d_nak) && d2a.sess == $past(a2d.sess))
        else $error("drive end did not answer open");
    chk_open_reply_a: assert property (
        d_open |=> (a_ack || a_nak) && a2d.sess == $past(d2a.sess))
        else $error("auto end did not answer open");
    chk_ack_cause_d: assert property (d_ack |-> $past(a_open))
        else $error("drive ack without open");
    chk_ack_cause_a: assert property (a_ack |-> $past(d_open))
        else $error("auto ack without open");
    chk_cack_cause_d: assert property (
        d_cack |-> $past(a_close) && d2a.sess == $past(a2d.sess))
        else $error("drive close ack without close");
    chk_cack_cause_a: assert property (
        a_cack |-> $past(d_close) && a2d.sess == $past(d2a.sess))
        else $error("auto close ack without close");
    // a duplicate close only follows an ack landing on a live session
    chk_dup_cause_d: assert property (
        d_dup |-> $past(a_ack) && d2a.sess == $past(a2d.sess))
        else $error("drive duplicate close without ack");
    chk_dup_cause_a: assert property (
        a_dup |-> $past(d_ack) && a2d.sess == $past(d2a.sess))
        else $error("auto duplicate close without ack");

    cov_tls_open: cover property (a_open && a2d.flag);
    cov_close_ack: cover property (d_cack);
    cov_reset_line: cover property (reset_a);
    cov_dup_close: cover property (d_dup);
endmodule

// ### test/port_connection_manager_tb_top.sv
// scenario testbench joining both ends of the connection layer
module port_connection_manager_tb_top;
    import pcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // index 0 is the automation end, 1 the drive end
    logic      core_clk = 1'b0;
    logic      reset    = 1'b1;
    logic      smode, phys, listen, rst_rx;
    logic      rv [2], rt [2], rr [2], cv [2], iv [2];
    req_kind_t rk [2], ck [2];
    sess_t     rs [2], cs [2], is [2];
    char_t     rd [2], id [2];
    status_t   st [2];
    ind_kind_t ik [2];
    int        miscompares = 0;
    int        tests_run   = 0;

    always #50 core_clk = ~core_clk;

    port_link_if port_link_if_inst (.core_clk(core_clk));

    auto_port_end auto_port_end_inst (
        .core_clk(core_clk), .reset(reset), .serial_mode(smode), .phys_attached(phys),
        .listen_en(listen), .req_valid(rv[0]), .req_kind(rk[0]), .req_sess(rs[0]),
        .req_data(rd[0]), .req_tls(rt[0]), .req_ready(rr[0]), .cnf_valid(cv[0]),
        .cnf_kind(ck[0]), .cnf_sess(cs[0]), .cnf_status(st[0]), .ind_valid(iv[0]),
        .ind_kind(ik[0]), .ind_sess(is[0]), .ind_data(id[0]), .link(port_link_if_inst));

    drive_port_end drive_port_end_inst (
        .core_clk(core_clk), .reset(reset), .serial_mode(smode), .phys_attached(phys),
        .req_valid(rv[1]), .req_kind(rk[1]), .req_sess(rs[1]), .req_data(rd[1]),
        .req_tls(rt[1]), .req_ready(rr[1]), .cnf_valid(cv[1]), .cnf_kind(ck[1]),
        .cnf_sess(cs[1]), .cnf_status(st[1]), .ind_valid(iv[1]), .ind_kind(ik[1]),
        .ind_sess(is[1]), .ind_data(id[1]), .reset_received(rst_rx),
        .link(port_link_if_inst));

    port_connection_manager_sva port_connection_manager_sva_inst (
        .core_clk(core_clk), .reset(reset), .a2d(port_link_if_inst.a2d),
        .d2a(port_link_if_inst.d2a), .reset_a(port_link_if_inst.reset_a));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one request held until taken, then its confirmation judged next cycle
    task automatic req(input int e, input req_kind_t k, input sess_t s, input char_t d,
                       input logic t, input status_t x);
        int n;
        @(posedge core_clk);
        rv[e] <= 1'b1;
        rk[e] <= k;
        rs[e] <= s;
        rd[e] <= d;
        rt[e] <= t;
        n = 0;
        do @(posedge core_clk); while (rr[e] !== 1'b1 && ++n < 20);
        rv[e] <= 1'b0;
        @(negedge core_clk);
        check("cnf_valid", 8'h01, cv[e]);
        check("cnf_kind", k, ck[e]);
        check("cnf_sess", s, cs[e]);
        check("cnf_status", x, st[e]);
    endtask

    // bounded wait for the next indication pulse on one end
    task automatic wait_ind(input int e, input ind_kind_t k, input sess_t s, input char_t d);
        int n;
        n = 0;
        do begin @(negedge core_clk); n++; end while (iv[e] !== 1'b1 && n < 10);
        check("ind_valid", 8'h01, iv[e]);
        check("ind_kind", k, ik[e]);
        check("ind_sess", s, is[e]);
        if (k == IND_RECEIVED) check("ind_data", d, id[e]);
    endtask

    task automatic no_ind(input int e);
        repeat (6) begin @(negedge core_clk); check("ind_quiet", 8'h00, iv[e]); end
    endtask

    task automatic t_connect();
        req(0, REQ_CONNECT, 2'h1, 8'h00, 1'b0, RSP_GOOD);
        wait_ind(1, IND_CONNECTED, 2'h1, 8'h00);
        wait_ind(0, IND_CONNECTED, 2'h1, 8'h00);
    endtask

    task automatic t_refuse();
        req(0, REQ_CONNECT, 2'h1, 8'h00, 1'b0, RSP_INVALID_STATE);
        req(1, REQ_CONNECT, 2'h1, 8'h00, 1'b0, RSP_INVALID_STATE);
        req(0, REQ_SEND, 2'h2, 8'h11, 1'b0, RSP_INVALID_STATE);
        req(1, REQ_RESET, 2'h0, 8'h00, 1'b0, RSP_NOT_SUPPORTED);
        @(posedge core_clk);
        phys <= 1'b0;
        req(0, REQ_CONNECT, 2'h2, 8'h00, 1'b0, RSP_NO_PHYS);
        @(posedge core_clk);
        phys <= 1'b1;
    endtask

    task automatic t_chars();
        req(1, REQ_RECEIVE, 2'h1, 8'h00, 1'b0, RSP_GOOD);
        req(0, REQ_SEND, 2'h1, 8'h5a, 1'b0, RSP_GOOD);
        wait_ind(1, IND_RECEIVED, 2'h1, 8'h5a);
        req(0, REQ_SEND, 2'h1, 8'ha5, 1'b0, RSP_GOOD);
        no_ind(1);
        req(0, REQ_RECEIVE, 2'h1, 8'h00, 1'b0, RSP_GOOD);
        req(1, REQ_SEND, 2'h1, 8'h3c, 1'b0, RSP_GOOD);
        wait_ind(0, IND_RECEIVED, 2'h1, 8'h3c);
    endtask

    task automatic t_disc_reopen();
        req(0, REQ_DISCONNECT, 2'h1, 8'h00, 1'b0, RSP_GOOD);
        wait_ind(1, IND_DISCONNECT_RECEIVED, 2'h1, 8'h00);
        wait_ind(0, IND_DISCONNECTED, 2'h1, 8'h00);
        req(0, REQ_SEND, 2'h1, 8'h22, 1'b0, RSP_INVALID_STATE);
        req(0, REQ_DISCONNECT, 2'h1, 8'h00, 1'b0, RSP_INVALID_STATE);
        req(1, REQ_CONNECT, 2'h1, 8'h00, 1'b1, RSP_GOOD);
        wait_ind(0, IND_CONNECTED, 2'h1, 8'h00);
        wait_ind(1, IND_CONNECTED, 2'h1, 8'h00);
        req(0, REQ_RECEIVE, 2'h1, 8'h00, 1'b0, RSP_GOOD);
        req(1, REQ_SEND, 2'h1, 8'h69, 1'b0, RSP_GOOD);
        wait_ind(0, IND_RECEIVED, 2'h1, 8'h69);
        @(posedge core_clk);
        listen <= 1'b0;
        req(1, REQ_CONNECT, 2'h2, 8'h00, 1'b0, RSP_GOOD);
        wait_ind(1, IND_CONNECT_FAILED, 2'h2, 8'h00);
        @(posedge core_clk);
        listen <= 1'b1;
    endtask

    task automatic t_reset_line();
        req(0, REQ_RESET, 2'h0, 8'h00, 1'b0, RSP_GOOD);
        @(negedge core_clk);
        check("reset_received", 8'h01, rst_rx);
        @(negedge core_clk);
        check("reset_received", 8'h00, rst_rx);
    endtask

    // serial mode: session 0 exists only while attached
    task automatic t_serial();
        @(posedge core_clk);
        smode <= 1'b1;
        req(0, REQ_CONNECT, 2'h0, 8'h00, 1'b0, RSP_NOT_SUPPORTED);
        req(1, REQ_DISCONNECT, 2'h0, 8'h00, 1'b0, RSP_NOT_SUPPORTED);
        req(1, REQ_RECEIVE, 2'h0, 8'h00, 1'b0, RSP_GOOD);
        req(0, REQ_SEND, 2'h0, 8'h77, 1'b0, RSP_GOOD);
        wait_ind(1, IND_RECEIVED, 2'h0, 8'h77);
        @(posedge core_clk);
        phys <= 1'b0;
        req(0, REQ_SEND, 2'h0, 8'h78, 1'b0, RSP_INVALID_STATE);
    endtask

    // crossed opens on one session: one connected each, drive drops its own
    task automatic t_dup();
        int n;
        @(posedge core_clk);
        for (int e = 0; e < 2; e++) begin
            rv[e] <= 1'b1;
            rk[e] <= REQ_CONNECT;
            rs[e] <= 2'h3;
            rt[e] <= 1'b0;
        end
        n = 0;
        do @(posedge core_clk); while ((rr[0] & rr[1]) !== 1'b1 && ++n < 20);
        rv[0] <= 1'b0;
        rv[1] <= 1'b0;
        @(negedge core_clk);
        for (int e = 0; e < 2; e++) begin
            check("cnf_valid", 8'h01, cv[e]);
            check("cnf_status", RSP_GOOD, st[e]);
        end
        @(negedge core_clk);
        for (int e = 0; e < 2; e++) begin
            check("ind_valid", 8'h01, iv[e]);
            check("ind_kind", IND_CONNECTED, ik[e]);
        end
        repeat (6) begin
            @(negedge core_clk);
            check("dup_quiet", 8'h00, {iv[0], iv[1]});
        end
        req(0, REQ_RECEIVE, 2'h3, 8'h00, 1'b0, RSP_GOOD);
        req(1, REQ_SEND, 2'h3, 8'h96, 1'b0, RSP_GOOD);
        wait_ind(0, IND_RECEIVED, 2'h3, 8'h96);
        req(1, REQ_DISCONNECT, 2'h3, 8'h00, 1'b0, RSP_GOOD);
        wait_ind(0, IND_DISCONNECT_RECEIVED, 2'h3, 8'h00);
        wait_ind(1, IND_DISCONNECTED, 2'h3, 8'h00);
    endtask

    // watchdog sized well past the hundred or so cycles the scenarios need
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        smode = 1'b0;
        phys = 1'b1;
        listen = 1'b1;
        for (int i = 0; i < 2; i++) begin
            rv[i] = 1'b0; rk[i] = REQ_SEND; rs[i] = 2'h0; rd[i] = 8'h00; rt[i] = 1'b0;
        end
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_connect();
        t_refuse();
        t_chars();
        t_disc_reopen();
        t_reset_line();
        t_dup();
        t_serial();
        tally_and_finish();
    end
endmodule
